// >>> core/pdsea_ea_adjust.sv
`timescale 1ns/100ps
`include "pdsea_consts.svh"

module pdsea_ea_adjust import pdsea_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        readPageLoad,
  input  wire logic        writePageLoad,
  input  wire logic [9:0]  pageLoadData,
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire pdsea_mode_t reqMode,
  input  wire logic [15:0] reqBase,
  input  wire logic [15:0] reqOffset,
  output logic [9:0]       readPageSelect,
  output logic [9:0]       writePageSelect,
  output logic             eaValid,
  output logic [15:0]      effectiveAddress,
  output logic [15:0]      pointerUpdate,
  output logic [9:0]       activePageSelect,
  output logic             addrErrorTrap
);

  pdsea_state_t q;
  pdsea_state_t d;
  logic [9:0]   actPage;
  logic         trapNow;
  logic         go;
  logic         actHigh;
  logic [9:0]   actNext;
  logic [15:0]  ptrNext;

  // Modes whose access address is the unmodified pointer
  function automatic logic usesBase(input pdsea_mode_t mode);
    return (mode == PDSEA_MODE_POST) || (mode == PDSEA_MODE_DIRECT);
  endfunction

  pdsea_calc_if cIf ();
  pdsea_adj_if  adjRd ();
  pdsea_adj_if  adjWr ();

  // Address sum and boundary detection
  pdsea_ea_calc u_calc (
    .cIf (cIf.calc)
  );

  // Read page adjust
  pdsea_page_adj u_adj_rd (
    .a (adjRd.adj)
  );

  // Write page adjust
  pdsea_page_adj u_adj_wr (
    .a (adjWr.adj)
  );

  // Request to the calculator
  always_comb begin
    cIf.base = reqBase;
    cIf.offset = reqOffset;
    cIf.mode = reqMode;
  end

  // Trap decode and page adjust requests
  always_comb begin
    actPage = reqWrite ? q.writePage : q.readPage;
    trapNow = reqValid && reqBase[`PDSEA_WIN_BIT] &&
              ((actPage == `PDSEA_PAGE_ZERO) ||
               (reqWrite && q.writePage >= `PDSEA_PSV_LSW_FIRST));
    go = reqValid && !trapNow;
    adjRd.page = q.readPage;
    adjRd.isRead = 1'b1;
    adjRd.ovf = go && !reqWrite && cIf.linear && cIf.ovf;
    adjRd.unf = go && !reqWrite && cIf.linear && cIf.unf;
    adjWr.page = q.writePage;
    adjWr.isRead = 1'b0;
    adjWr.ovf = go && reqWrite && cIf.linear && cIf.ovf;
    adjWr.unf = go && reqWrite && cIf.linear && cIf.unf;
    actHigh = reqWrite ? adjWr.highBit : adjRd.highBit;
    actNext = reqWrite ? adjWr.nextPage : adjRd.nextPage;
  end

  // Final window bit of the modified pointer
  always_comb begin
    ptrNext = cIf.sum;
    if (cIf.ovf || cIf.unf) begin
      if (cIf.linear) begin
        ptrNext[`PDSEA_WIN_BIT] = actHigh;
      end else if (cIf.wrap) begin
        ptrNext[`PDSEA_WIN_BIT] = 1'b1;
      end
    end
    if (reqMode == PDSEA_MODE_DIRECT) begin
      ptrNext = reqBase;
    end
  end

  // Next state
  always_comb begin
    d = q;
    d.eaValid = go;
    d.trap = trapNow;
    if (go) begin
      d.ptr = ptrNext;
      d.ea = usesBase(reqMode) ? reqBase : ptrNext;
      d.pageUsed = (reqMode == PDSEA_MODE_PRE) ? actNext : actPage;
      // Only linear modes move a page register
      if (cIf.linear) begin
        if (reqWrite) begin
          d.writePage = adjWr.nextPage;
        end else begin
          d.readPage = adjRd.nextPage;
        end
      end
    end
    // Core loads take priority over an adjust in the same cycle
    if (readPageLoad) begin
      d.readPage = pageLoadData;
    end
    if (writePageLoad) begin
      d.writePage = pageLoadData;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.readPage <= `PDSEA_RD_PAGE_RST;
      q.writePage <= `PDSEA_WR_PAGE_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state
  assign readPageSelect = q.readPage;
  assign writePageSelect = q.writePage;
  assign eaValid = q.eaValid;
  assign effectiveAddress = q.ea;
  assign pointerUpdate = q.ptr;
  assign activePageSelect = q.pageUsed;
  assign addrErrorTrap = q.trap;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic noLoad;
  assign noLoad = !readPageLoad && !writePageLoad;

  raw_bit_clear_a: assert property ((cIf.ovf || cIf.unf) |-> !cIf.sum[15])
    else $error("raw address bit 15 not cleared on crossing");

  read_uses_rdpage_a: assert property (
    reqValid && !reqWrite && !trapNow && reqMode == PDSEA_MODE_POST |=>
      eaValid && activePageSelect == $past(readPageSelect))
    else $error("read access did not use read page");

  write_keeps_rd_a: assert property (
    reqValid && reqWrite && noLoad |=> $stable(readPageSelect))
    else $error("write access changed read page");

  regofs_no_page_a: assert property (
    reqValid && reqMode == PDSEA_MODE_REGOFS && noLoad |=>
      $stable(readPageSelect) && $stable(writePageSelect))
    else $error("register offset mode moved a page");

  linear_incr_a: assert property (
    go && !reqWrite && reqMode == PDSEA_MODE_PRE && cIf.ovf && noLoad &&
    q.readPage < `PDSEA_EDS_LAST |=>
      readPageSelect == $past(readPageSelect) + 10'h001 && effectiveAddress[15])
    else $error("read page not incremented on overflow");

  linear_decr_a: assert property (
    go && reqWrite && reqMode == PDSEA_MODE_POST && cIf.unf && noLoad &&
    q.writePage > `PDSEA_EDS_FIRST |=>
      writePageSelect == $past(writePageSelect) - 10'h001 && pointerUpdate[15])
    else $error("write page not decremented on underflow");

  wrap_keep_page_a: assert property (
    go && cIf.wrap && (cIf.ovf || cIf.unf) && noLoad |=>
      $stable(readPageSelect) && $stable(writePageSelect) && effectiveAddress[15])
    else $error("wrap mode crossing changed page or cleared bit 15");

  eds_last_stop_a: assert property (
    go && !reqWrite && cIf.linear && cIf.ovf && noLoad && q.readPage == `PDSEA_EDS_LAST |=>
      readPageSelect == 10'h1FF && !pointerUpdate[15])
    else $error("overflow from last data page not to base space");

  lsw_to_msw_a: assert property (
    go && !reqWrite && cIf.linear && cIf.ovf && noLoad && q.readPage == `PDSEA_PSV_LSW_LAST |=>
      readPageSelect == 10'h300 && pointerUpdate[15])
    else $error("lower to upper visibility page step failed");

  page_zero_trap_a: assert property (
    reqValid && reqBase[15] && !reqWrite && q.readPage == `PDSEA_PAGE_ZERO |=>
      addrErrorTrap && !eaValid ##1 (!addrErrorTrap || $past(reqValid)))
    else $error("page zero window access did not trap");

  psv_write_trap_a: assert property (
    reqValid && reqWrite && reqBase[15] && q.writePage >= `PDSEA_PSV_LSW_FIRST |=>
      addrErrorTrap && !eaValid && ($stable(writePageSelect) || $past(writePageLoad)))
    else $error("program space write did not trap");

  // Page selection and load checks
  write_uses_wrpage_a: assert property (
    reqValid && reqWrite && !trapNow && reqMode == PDSEA_MODE_POST |=>
      eaValid && activePageSelect == $past(writePageSelect))
    else $error("write access did not use write page");

  read_load_a: assert property (
    readPageLoad |=> readPageSelect == $past(pageLoadData))
    else $error("read page load not taken");

  write_load_a: assert property (
    writePageLoad |=> writePageSelect == $past(pageLoadData))
    else $error("write page load not taken");

  read_keeps_wr_a: assert property (
    reqValid && !reqWrite && noLoad |=> $stable(writePageSelect))
    else $error("read access changed write page");

  // Address, page and answer timing checks
  post_addr_base_a: assert property (
    go && usesBase(reqMode) |=> effectiveAddress == $past(reqBase))
    else $error("post or direct access address not the unmodified pointer");

  direct_ptr_base_a: assert property (
    go && reqMode == PDSEA_MODE_DIRECT |=> pointerUpdate == $past(reqBase))
    else $error("direct access changed the pointer");

  outside_no_cross_a: assert property (
    go && !reqBase[`PDSEA_WIN_BIT] && noLoad |=> $stable(readPageSelect) && $stable(writePageSelect))
    else $error("access outside the window moved a page");

  pre_page_used_a: assert property (
    go && reqMode == PDSEA_MODE_PRE && noLoad |=>
      activePageSelect == ($past(reqWrite) ? writePageSelect : readPageSelect))
    else $error("pre modified access did not use the adjusted page");

  wrap_ptr_set_a: assert property (
    go && cIf.wrap && (cIf.ovf || cIf.unf) |=>
      pointerUpdate[15] && activePageSelect == $past(actPage))
    else $error("wrap mode crossing left bit 15 clear or used another page");

  answer_next_a: assert property (
    reqValid |=> eaValid ^ addrErrorTrap)
    else $error("request not answered in the next cycle");

  no_idle_answer_a: assert property (
    !reqValid |=> !eaValid && !addrErrorTrap)
    else $error("answer without a request");

  // Boundary page checks
  msw_to_lsw_a: assert property (
    go && !reqWrite && cIf.linear && cIf.unf && noLoad && q.readPage == `PDSEA_PSV_MSW_FIRST |=>
      readPageSelect == `PDSEA_PSV_LSW_LAST && pointerUpdate[15])
    else $error("upper to lower visibility page step failed");

  first_page_stop_a: assert property (
    go && cIf.linear && cIf.unf && noLoad && actPage == `PDSEA_EDS_FIRST |=>
      $stable(readPageSelect) && $stable(writePageSelect) && !pointerUpdate[15])
    else $error("underflow from first data page not to base space");

  lsw_first_stop_a: assert property (
    go && !reqWrite && cIf.linear && cIf.unf && noLoad && q.readPage == `PDSEA_PSV_LSW_FIRST |=>
      $stable(readPageSelect) && !pointerUpdate[15])
    else $error("underflow from first lower page not to base space");

  msw_last_stop_a: assert property (
    go && !reqWrite && cIf.linear && cIf.ovf && noLoad && q.readPage == `PDSEA_PSV_MSW_LAST |=>
      $stable(readPageSelect) && !pointerUpdate[15])
    else $error("overflow from last upper page not to base space");

  eds_last_wr_stop_a: assert property (
    go && reqWrite && cIf.linear && cIf.ovf && noLoad && q.writePage == `PDSEA_EDS_LAST |=>
      $stable(writePageSelect) && !pointerUpdate[15])
    else $error("write overflow from last data page not to base space");

  // Trap checks
  trap_keeps_addr_a: assert property (
    trapNow |=> addrErrorTrap && $stable(effectiveAddress) && $stable(pointerUpdate) &&
      $stable(activePageSelect))
    else $error("trapped access changed address outputs");

  trap_no_page_a: assert property (
    trapNow && noLoad |=> $stable(readPageSelect) && $stable(writePageSelect))
    else $error("trapped access moved a page");

  cover_rd_ovf_c: cover property (go && !reqWrite && cIf.linear && cIf.ovf);
  cover_wr_unf_c: cover property (go && reqWrite && cIf.linear && cIf.unf);
  cover_wrap_c: cover property (go && cIf.wrap && cIf.ovf);
  cover_trap_c: cover property (trapNow ##1 reqValid);
  cover_msw_lsw_c: cover property (go && !reqWrite && cIf.unf && q.readPage == `PDSEA_PSV_MSW_FIRST);

endmodule

// >>> core/pdsea_consts.svh
`ifndef PDSEA_CONSTS_SVH
`define PDSEA_CONSTS_SVH

// Page register width and page boundary values
`define PDSEA_PAGE_W        10
`define PDSEA_PAGE_ZERO     10'h000
`define PDSEA_EDS_FIRST     10'h001
`define PDSEA_EDS_LAST      10'h1FF
`define PDSEA_PSV_LSW_FIRST 10'h200
`define PDSEA_PSV_LSW_LAST  10'h2FF
`define PDSEA_PSV_MSW_FIRST 10'h300
`define PDSEA_PSV_MSW_LAST  10'h3FF
`define PDSEA_PAGE_ONE      10'h001

// Window select bit position of the effective address
`define PDSEA_WIN_BIT       15

// Reset values of the page registers
`define PDSEA_RD_PAGE_RST   10'h001
`define PDSEA_WR_PAGE_RST   10'h001

`endif

// >>> core/pdsea_pkg.sv
package pdsea_pkg;

  // Addressing mode of the current effective-address calculation
  typedef enum logic [2:0] {
    PDSEA_MODE_DIRECT = 3'h0,
    PDSEA_MODE_PRE    = 3'h1,
    PDSEA_MODE_POST   = 3'h3,
    PDSEA_MODE_REGOFS = 3'h2,
    PDSEA_MODE_MODULO = 3'h6,
    PDSEA_MODE_BITREV = 3'h7
  } pdsea_mode_t;

  // Whole state of the top module
  typedef struct packed {
    logic [9:0]  readPage;
    logic [9:0]  writePage;
    logic        eaValid;
    logic        trap;
    logic [15:0] ea;
    logic [15:0] ptr;
    logic [9:0]  pageUsed;
  } pdsea_state_t;

endpackage

// >>> core/pdsea_if.sv
`timescale 1ns/100ps

// Page adjust request and answer
interface pdsea_adj_if;
  logic [9:0] page;
  logic       isRead;
  logic       ovf;
  logic       unf;
  logic [9:0] nextPage;
  logic       highBit;
  modport adj (input page, input isRead, input ovf, input unf, output nextPage, output highBit);
  modport req (output page, output isRead, output ovf, output unf, input nextPage, input highBit);
endinterface

// Effective-address sum and boundary detection
interface pdsea_calc_if;
  import pdsea_pkg::*;
  logic [15:0] base;
  logic [15:0] offset;
  pdsea_mode_t mode;
  logic [15:0] sum;
  logic        ovf;
  logic        unf;
  logic        linear;
  logic        wrap;
  modport calc (input base, input offset, input mode,
                output sum, output ovf, output unf, output linear, output wrap);
  modport req (output base, output offset, output mode,
               input sum, input ovf, input unf, input linear, input wrap);
endinterface

// >>> core/pdsea_ea_calc.sv
`timescale 1ns/100ps
`include "pdsea_consts.svh"

module pdsea_ea_calc import pdsea_pkg::*; (
  pdsea_calc_if.calc cIf
);

  logic [17:0] sumWide;
  logic        inWin;

  // Signed sum, window test and boundary detection
  always_comb begin
    sumWide = {2'b00, cIf.base} + {{2{cIf.offset[15]}}, cIf.offset};
    inWin = cIf.base[`PDSEA_WIN_BIT];
    cIf.linear = (cIf.mode == PDSEA_MODE_PRE) || (cIf.mode == PDSEA_MODE_POST);
    cIf.wrap = (cIf.mode == PDSEA_MODE_REGOFS) || (cIf.mode == PDSEA_MODE_MODULO) ||
               (cIf.mode == PDSEA_MODE_BITREV);
    // Only an unmodified address in the window can cross a page
    cIf.ovf = inWin && (sumWide[17:16] == 2'b01);
    cIf.unf = inWin && (sumWide[17] || (sumWide[16:15] == 2'b00));
    cIf.sum = sumWide[15:0];
    if (cIf.ovf || cIf.unf) begin
      cIf.sum[`PDSEA_WIN_BIT] = 1'b0;
    end
  end

endmodule

// >>> core/pdsea_page_adj.sv
`timescale 1ns/100ps
`include "pdsea_consts.svh"

module pdsea_page_adj import pdsea_pkg::*; (
  pdsea_adj_if.adj a
);

  // Next page and window bit after a crossing
  always_comb begin
    a.nextPage = a.page;
    a.highBit = 1'b1;
    if (a.ovf) begin
      if (a.page == `PDSEA_EDS_LAST || a.page == `PDSEA_PSV_MSW_LAST) begin
        a.highBit = 1'b0;
      end else if (a.isRead && a.page == `PDSEA_PSV_LSW_LAST) begin
        a.nextPage = `PDSEA_PSV_MSW_FIRST;
      end else begin
        a.nextPage = a.page + `PDSEA_PAGE_ONE;
      end
    end else if (a.unf) begin
      if (a.page == `PDSEA_EDS_FIRST || a.page == `PDSEA_PSV_LSW_FIRST) begin
        a.highBit = 1'b0;
      end else if (a.isRead && a.page == `PDSEA_PSV_MSW_FIRST) begin
        a.nextPage = `PDSEA_PSV_LSW_LAST;
      end else begin
        a.nextPage = a.page - `PDSEA_PAGE_ONE;
      end
    end
  end

endmodule

// >>> dv/pdsea_core_model.sv
`timescale 1ns/100ps

// Core address generator: issues page loads and address requests
module pdsea_core_model import pdsea_pkg::*; (
  input  wire logic   clk,
  output logic        readPageLoad,
  output logic        writePageLoad,
  output logic [9:0]  pageLoadData,
  output logic        reqValid,
  output logic        reqWrite,
  output pdsea_mode_t reqMode,
  output logic [15:0] reqBase,
  output logic [15:0] reqOffset
);
  // Idle values at time zero
  initial begin
    readPageLoad = 1'b0;
    writePageLoad = 1'b0;
    pageLoadData = 10'h000;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqMode = PDSEA_MODE_DIRECT;
    reqBase = 16'h0000;
    reqOffset = 16'h0000;
  end

  // One page load, launched after an edge and held over the taking edge
  task automatic load(input logic wr, input logic [9:0] pg);
    @(posedge clk);
    #1;
    readPageLoad = !wr;
    writePageLoad = wr;
    pageLoadData = pg;
    @(posedge clk);
    #1;
    readPageLoad = 1'b0;
    writePageLoad = 1'b0;
    pageLoadData = ~pg; // Stale value not left behind
  endtask

  // One request; offsets kept to a single page step
  task automatic issue(input logic wr, input pdsea_mode_t md, input logic [15:0] b, input logic [15:0] o);
    @(posedge clk);
    #1;
    reqValid = 1'b1;
    reqWrite = wr;
    reqMode = md;
    reqBase = b;
    reqOffset = o;
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    reqBase = ~b; // Released base and offset lines do not keep the old value
    reqOffset = ~o;
  endtask
endmodule

// >>> dv/pdsea_ea_adjust_tb.sv
`timescale 1ns/100ps

module pdsea_ea_adjust_tb;
  import pdsea_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rdLd, wrLd, reqValid, reqWrite, eaValid, trap;
  logic [9:0]  ldData, rdPg, wrPg, actPg, rpE, wpE, aE;
  logic [15:0] reqBase, reqOffset, ea, ptr, eE, pE;
  pdsea_mode_t reqMode;
  pdsea_mode_t wm [3] = '{PDSEA_MODE_REGOFS, PDSEA_MODE_MODULO, PDSEA_MODE_BITREV};
  int          miscompares = 0;
  int          compares = 0;

  // Core clock, 8 ns period
  always #4 clk = ~clk;

  pdsea_ea_adjust pdsea_ea_adjust_inst (.clk(clk), .rst(rst), .readPageLoad(rdLd), .writePageLoad(wrLd),
    .pageLoadData(ldData), .reqValid(reqValid), .reqWrite(reqWrite), .reqMode(reqMode), .reqBase(reqBase),
    .reqOffset(reqOffset), .readPageSelect(rdPg), .writePageSelect(wrPg), .eaValid(eaValid),
    .effectiveAddress(ea), .pointerUpdate(ptr), .activePageSelect(actPg), .addrErrorTrap(trap));

  pdsea_core_model pdsea_core_model_inst (.clk(clk), .readPageLoad(rdLd), .writePageLoad(wrLd),
    .pageLoadData(ldData), .reqValid(reqValid), .reqWrite(reqWrite), .reqMode(reqMode), .reqBase(reqBase),
    .reqOffset(reqOffset));

  // Verdict and end of run
  task automatic close_out();
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Value comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Page load with check of the loaded page
  task automatic ld(input logic wr, input logic [9:0] pg);
    pdsea_core_model_inst.load(wr, pg);
    if (wr) begin
      wpE = pg;
    end else begin
      rpE = pg;
    end
    chk(wr ? wrPg : rdPg, pg);
  endtask

  // Request, answer within a bounded wait, full output check
  task automatic rq(input logic wr, input pdsea_mode_t md, input logic [15:0] b, input logic [15:0] o,
                    input logic tr, input logic [15:0] p, input logic [9:0] np);
    int n;
    logic [9:0] op;
    op = wr ? wpE : rpE;
    pdsea_core_model_inst.issue(wr, md, b, o);
    for (n = 0; n < 4 && eaValid !== 1'b1 && trap !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 4) begin
      miscompares++;
      close_out();
    end
    if (!tr) begin
      pE = p;
      eE = (md == PDSEA_MODE_POST) ? b : p;
      aE = (md == PDSEA_MODE_PRE) ? np : op;
      if (wr) begin
        wpE = np;
      end else begin
        rpE = np;
      end
    end
    chk(trap, tr);
    chk(eaValid, !tr);
    chk(ea, eE);
    chk(ptr, pE);
    chk(actPg, aE);
    chk(rdPg, rpE);
    chk(wrPg, wpE);
    @(posedge clk);
    #1;
    chk(eaValid | trap, 16'h0000); // Answer lasts one cycle
  endtask

  // Values right after reset
  task automatic t_reset();
    rpE = 10'h001;
    wpE = 10'h001;
    eE = 16'h0000;
    pE = 16'h0000;
    aE = 10'h000;
    chk(rdPg, rpE);
    chk(wrPg, wpE);
    chk(ea, eE);
    chk(ptr, pE);
    chk(actPg, aE);
    chk(eaValid | trap, 16'h0000);
  endtask

  // Linear crossing on separate read and write pages
  task automatic t_linear();
    ld(1'b0, 10'h005);
    rq(1'b0, PDSEA_MODE_PRE, 16'hfffe, 16'h0002, 1'b0, 16'h8000, 10'h006);
    ld(1'b1, 10'h010);
    rq(1'b1, PDSEA_MODE_POST, 16'h8000, 16'hfffe, 1'b0, 16'hfffe, 10'h00f);
  endtask

  // Boundary pages
  task automatic t_bounds();
    ld(1'b0, 10'h1ff);
    rq(1'b0, PDSEA_MODE_PRE, 16'hfffe, 16'h0002, 1'b0, 16'h0000, 10'h1ff);
    ld(1'b0, 10'h2ff);
    rq(1'b0, PDSEA_MODE_PRE, 16'hfffe, 16'h0002, 1'b0, 16'h8000, 10'h300);
    rq(1'b0, PDSEA_MODE_POST, 16'h8000, 16'hfffe, 1'b0, 16'hfffe, 10'h2ff);
    ld(1'b0, 10'h3ff);
    rq(1'b0, PDSEA_MODE_POST, 16'hfffe, 16'h0002, 1'b0, 16'h0000, 10'h3ff);
    ld(1'b1, 10'h1ff);
    rq(1'b1, PDSEA_MODE_PRE, 16'hfffe, 16'h0002, 1'b0, 16'h0000, 10'h1ff);
    ld(1'b0, 10'h001);
    rq(1'b0, PDSEA_MODE_PRE, 16'h8000, 16'hfffe, 1'b0, 16'h7ffe, 10'h001);
    ld(1'b0, 10'h200);
    rq(1'b0, PDSEA_MODE_POST, 16'h8000, 16'hfffe, 1'b0, 16'h7ffe, 10'h200);
  endtask

  // Wrapping modes, outside window, direct
  task automatic t_wrap();
    ld(1'b0, 10'h2ff);
    foreach (wm[i]) begin
      rq(1'b0, wm[i], 16'hfffe, 16'h0002, 1'b0, 16'h8000, 10'h2ff);
      rq(1'b0, wm[i], 16'h8000, 16'hfffe, 1'b0, 16'hfffe, 10'h2ff);
    end
    rq(1'b0, PDSEA_MODE_PRE, 16'h7ffe, 16'h0002, 1'b0, 16'h8000, 10'h2ff);
    rq(1'b0, PDSEA_MODE_DIRECT, 16'hfffe, 16'h0002, 1'b0, 16'hfffe, 10'h2ff);
  endtask

  // Address error traps
  task automatic t_trap();
    ld(1'b0, 10'h000);
    rq(1'b0, PDSEA_MODE_PRE, 16'hfffe, 16'h0002, 1'b1, 16'h0000, 10'h000);
    ld(1'b1, 10'h000);
    rq(1'b1, PDSEA_MODE_POST, 16'h8002, 16'h0002, 1'b1, 16'h0000, 10'h000);
    ld(1'b1, 10'h200);
    rq(1'b1, PDSEA_MODE_POST, 16'h8000, 16'hfffe, 1'b1, 16'h0000, 10'h200);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_linear();
    t_bounds();
    t_wrap();
    t_trap();
    close_out();
  end
endmodule
